// ### afc_cal_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "afc_cfg_regs.vh"

// calibration coefficient store, two registered read ports
module afc_cal_mem
(
  input  wire        mclk,    // system clock
  input  wire        we,      // write strobe
  input  wire [4:0]  waddr,   // write index
  input  wire [23:0] wdata,   // write word
  input  wire [4:0]  raddr_a, // serial read index
  output reg  [23:0] rdata_a, // serial read word
  input  wire [4:0]  raddr_b, // apply path index
  output reg  [23:0] rdata_b  // coefficient in use
);

  reg [23:0] mem_r [0:16];

  always @(posedge mclk)
  begin
    if (we && waddr <= `AFC_A_CAL_CUR)
      mem_r[waddr] <= wdata;
    rdata_a <= (raddr_a <= `AFC_A_CAL_CUR) ? mem_r[raddr_a] : 24'h000000;
    rdata_b <= (raddr_b <= `AFC_A_CAL_CUR) ? mem_r[raddr_b] : 24'h000000;
  end

endmodule // afc_cal_mem

`default_nettype wire

// ### afc_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module afc_cfg_props
(
  input wire logic        mclk,                 // clock
  input wire logic        srst,                 // reset
  input wire logic        sclk,                 // serial clock
  input wire logic        cs_n,                 // frame select
  input wire logic        miso_oe_n,            // out enable
  input wire logic        oc_det,               // overcurrent
  input wire logic        ov_det,               // overvoltage
  input wire logic        ot_det,               // overtemp
  input wire logic [43:0] filt_flat,            // filters
  input wire logic [95:0] gain_flat,            // gains
  input wire logic [95:0] offs_flat,            // offsets
  input wire logic [3:0]  chan_en,              // channels
  input wire logic [1:0]  adc_clk_sel,          // adc clock
  input wire logic [1:0]  afe_clk_sel,          // afe clock
  input wire logic        adc_osc_en,           // adc osc
  input wire logic        afe_osc_en,           // afe osc
  input wire logic        clock_inout_pin_oe_n, // pin drive
  input wire logic [2:0]  prot_flags,           // flags
  input wire logic        hv_shutdown           // shutdown
);
  // idle cycles since the last frame activity
  logic [5:0] quiet_r;
  always @(posedge mclk)
  begin
    if (srst || sclk || !cs_n)
      quiet_r <= 6'h00;
    else if (quiet_r != 6'h3f)
      quiet_r <= quiet_r + 6'h01;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  AST_ADC_OSC: assert property ((adc_clk_sel == $past(adc_clk_sel))[*3]
    |-> adc_osc_en == (adc_clk_sel != 2'h2)) else $error("adc osc enable wrong");
  AST_AFE_OSC: assert property ((afe_clk_sel == $past(afe_clk_sel))[*3]
    |-> afe_osc_en == (afe_clk_sel != 2'h2)) else $error("afe osc enable wrong");
  AST_PIN_OE: assert property ((adc_clk_sel == $past(adc_clk_sel))[*3]
    |-> clock_inout_pin_oe_n == (adc_clk_sel != 2'h1)) else $error("clock pin drive wrong");
  AST_HV_SHUT: assert property ((prot_flags == $past(prot_flags))[*3]
    |-> hv_shutdown == (|prot_flags)) else $error("shutdown not flag or");
  AST_PROT_OC: assert property ($rose(oc_det) |-> ##[1:6] prot_flags[0])
    else $error("oc flag late");
  AST_PROT_OV: assert property ($rose(ov_det) |-> ##[1:6] prot_flags[1])
    else $error("ov flag late");
  AST_PROT_OT: assert property ($rose(ot_det) |-> ##[1:6] prot_flags[2])
    else $error("ot flag late");
  AST_STICKY: assert property (quiet_r > 6'd10 && prot_flags[0] |=> prot_flags[0])
    else $error("flag cleared without frame");
  AST_QUIET: assert property (quiet_r > 6'd10
    |=> $stable(gain_flat) && $stable(offs_flat) && $stable(filt_flat))
    else $error("register changed without frame");
  AST_MISO_IDLE: assert property (cs_n[*6] |-> miso_oe_n)
    else $error("miso driven outside frame");
  AST_FILT_CH1: assert property (!chan_en[1] && $stable(chan_en)
    |=> $stable(filt_flat[21:11])) else $error("disabled filter written");
endmodule // afc_cfg_props

bind afc_cfg_top afc_cfg_props u_props (.mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
  .miso_oe_n(miso_oe_n), .oc_det(oc_det), .ov_det(ov_det), .ot_det(ot_det),
  .filt_flat(filt_flat), .gain_flat(gain_flat), .offs_flat(offs_flat), .chan_en(chan_en),
  .adc_clk_sel(adc_clk_sel), .afe_clk_sel(afe_clk_sel), .adc_osc_en(adc_osc_en),
  .afe_osc_en(afe_osc_en), .clock_inout_pin_oe_n(clock_inout_pin_oe_n),
  .prot_flags(prot_flags), .hv_shutdown(hv_shutdown));
`default_nettype wire

// ### afc_cfg_regs.vh
`ifndef AFC_CFG_REGS_VH
`define AFC_CFG_REGS_VH

// ****************************************
// serial frame layout
// ****************************************
`define AFC_CMD_BITS      6'd8
`define AFC_FRAME_LAST    6'd31
`define AFC_CMD_LAST      6'd7
`define AFC_CMD_DEV_HI    7
`define AFC_CMD_DEV_LO    6
`define AFC_CMD_RD        5
`define AFC_CMD_ADR_HI    4
`define AFC_DW            24

// ****************************************
// register addresses (5-bit)
// ****************************************
`define AFC_A_CAL_CUR     5'h10
`define AFC_A_FILT        5'h11
`define AFC_A_CHCFG       5'h12
`define AFC_A_GAIN0       5'h13
`define AFC_A_OFFS0       5'h17
`define AFC_A_AFE         5'h1b
`define AFC_A_STAT        5'h1c
`define AFC_A_DATA        5'h1d
`define AFC_NCH           4

// ****************************************
// channel configuration fields
// ****************************************
`define AFC_CH_EN_HI      3
`define AFC_CH_IMODE      4
`define AFC_CH_PGA_HI     8
`define AFC_CH_PGA_LO     5
`define AFC_CH_ACLK_HI    10
`define AFC_CH_ACLK_LO    9
`define AFC_CH_FCLK_HI    12
`define AFC_CH_FCLK_LO    11
`define AFC_CH_BIAS_VOLTAGE_GENERATOR      13
`define AFC_CH_W          14

// clock source codes
`define AFC_CLK_INT       2'h0
`define AFC_CLK_DRV       2'h1
`define AFC_CLK_PIN       2'h2

// ****************************************
// filter and front-end fields
// ****************************************
`define AFC_FILT_W        11
`define AFC_FT_SINC51     2'h0
`define AFC_FT_SINC3      2'h1
`define AFC_FT_ENH        2'h2
`define AFC_AFE_PULL_HI   7
`define AFC_AFE_EXC_HI    13
`define AFC_AFE_EXC_LO    8
`define AFC_AFE_W         14
`define AFC_ST_W          3

// ****************************************
// reset values
// ****************************************
`define AFC_SYNC_RST      8'h02
`define AFC_CH_RST        14'h0001
`define AFC_FILT_RST      11'h000
`define AFC_GAIN_RST      24'h400000
`define AFC_OFFS_RST      24'h800000
`define AFC_AFE_RST       14'h0000

`endif

// ### afc_cfg_top.v
// Notes on behaviour
// - four filter registers, one per channel, each holding its own data rate.
// - one shared filter address; a write copies into every enabled channel.
// - each of four channels has its own gain and offset register.
// - voltage mode applies one of sixteen coefficients chosen by amplifier gain.
// - current mode applies a seventeenth coefficient of its own, whatever the gain.
// - registers are reached only through the four-wire serial port.
// - a device answers only frames carrying its two-pin address.
// - two internal oscillators, one for converter, one for front end.
// - clock pin either drives the internal clock out or takes one in.
// - filter type selects sinc5 plus sinc1, sinc3 or enhanced rejection.
// - conversion results are 24 bits wide, at most 125 kSPS.
// - each input pin has pull-up or pull-down of 1 or 100 uA.
// - two excitation sources of 100, 400, 500 uA or combinations.
// - overcurrent, overvoltage, overtemperature flagged and input shut down.
// - bias generator tying negative input to ground is software switched.
`timescale 1ns/1ps
`default_nettype none
`include "afc_cfg_regs.vh"

module afc_cfg_top
(
  input  wire        mclk,            // system clock, 20 MHz
  input  wire        srst,            // synchronous reset
  input  wire        sclk,            // serial clock from host
  input  wire        cs_n,            // serial select, low active
  input  wire        mosi,            // serial data in
  output wire        miso_o,          // serial data out
  output wire        miso_oe_n,       // low while driving serial out
  input  wire        device_select_pin_low,  // address strap bit 0
  input  wire        device_select_pin_high, // address strap bit 1
  input  wire        oc_det,          // overcurrent detector
  input  wire        ov_det,          // overvoltage detector
  input  wire        ot_det,          // overtemperature detector
  input  wire [23:0] conv_data,       // converter result
  input  wire        conv_valid,      // result strobe
  output wire [43:0] filt_flat,       // four filter words
  output wire [95:0] gain_flat,       // four gain words
  output wire [95:0] offs_flat,       // four offset words
  output wire [3:0]  chan_en,         // enabled channels
  output wire        imode,           // current mode
  output wire [3:0]  pga_gain,        // amplifier gain code
  output wire [1:0]  adc_clk_sel,     // converter clock source
  output wire [1:0]  afe_clk_sel,     // front-end clock source
  output reg         adc_osc_en,      // converter oscillator on
  output reg         afe_osc_en,      // front-end oscillator on
  output reg         clock_inout_pin_oe_n, // low while pin drives clock
  output wire        bias_voltage_generator_en, // bias generator on
  output wire [7:0]  pull_ctrl,       // open-wire pull enables
  output wire [5:0]  excite_ctrl,     // excitation enables, two x3
  output wire [2:0]  prot_flags,      // sticky ot, ov, oc
  output reg         hv_shutdown,     // high-voltage input off
  output wire [23:0] gain_coef        // calibration coefficient applied
);

  // ****************************************
  // synchronisers
  // ****************************************
  reg  [7:0]  in_s1_r;
  reg  [7:0]  in_s2_r;
  reg         sclk_q_r;
  wire        sclk_s  = in_s2_r[0];
  wire        cs_n_s  = in_s2_r[1];
  wire        mosi_s  = in_s2_r[2];
  wire [1:0]  dev_s   = in_s2_r[4:3];
  wire [2:0]  prot_s  = in_s2_r[7:5];
  wire        sck_rise = sclk_s & ~sclk_q_r & ~cs_n_s;
  wire        sck_fall = ~sclk_s & sclk_q_r & ~cs_n_s;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      in_s1_r  <= `AFC_SYNC_RST;
      in_s2_r  <= `AFC_SYNC_RST;
      sclk_q_r <= 1'b0;
    end
    else
    begin
      in_s1_r  <= {ot_det, ov_det, oc_det, device_select_pin_high,
                   device_select_pin_low, mosi, cs_n, sclk};
      in_s2_r  <= in_s1_r;
      sclk_q_r <= sclk_s;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  // lowest enabled channel, used for filter read-back
  function [1:0] low_chan;
    input [3:0] en;
    begin
      low_chan = en[0] ? 2'd0 : en[1] ? 2'd1 : en[2] ? 2'd2 : en[3] ? 2'd3 : 2'd0;
    end
  endfunction

  // true when a lies in the 4-word bank starting at base
  function in_bank;
    input [4:0] a;
    input [4:0] base;
    begin
      in_bank = (a >= base) && (a < base + 5'd4);
    end
  endfunction

  // word index inside a 4-word bank, cut to two bits on purpose
  function [1:0] bank_idx;
    input [4:0] a;
    input [4:0] base;
    reg   [4:0] diff;
    begin
      diff     = a - base;
      bank_idx = diff[1:0];
    end
  endfunction

  // ****************************************
  // serial frame engine
  // ****************************************
  reg  [5:0]  bit_cnt_r;
  reg  [31:0] sh_in_r;
  reg  [7:0]  cmd_r;
  reg  [23:0] sh_out_r;
  reg         load_pend_r;
  reg         load_go_r;
  reg         frame_done_r;
  reg  [23:0] rd_mux;
  wire        sel     = (cmd_r[`AFC_CMD_DEV_HI:`AFC_CMD_DEV_LO] == dev_s);
  wire        is_rd   = cmd_r[`AFC_CMD_RD];
  wire [4:0]  addr    = cmd_r[`AFC_CMD_ADR_HI:0];
  wire        wr_stb  = frame_done_r & sel & ~is_rd;
  wire [23:0] wdat    = sh_in_r[23:0];
  wire [1:0]  bidx    = bank_idx(addr, `AFC_A_GAIN0);
  wire [1:0]  oidx    = bank_idx(addr, `AFC_A_OFFS0);

  always @(posedge mclk)
  begin
    if (srst)
    begin
      bit_cnt_r    <= 6'd0;
      sh_in_r      <= 32'h00000000;
      cmd_r        <= 8'h00;
      sh_out_r     <= 24'h000000;
      load_pend_r  <= 1'b0;
      load_go_r    <= 1'b0;
      frame_done_r <= 1'b0;
    end
    else
    begin
      load_pend_r  <= 1'b0;
      load_go_r    <= load_pend_r;
      frame_done_r <= 1'b0;
      if (cs_n_s)
        bit_cnt_r <= 6'd0; // aborted frames leave the registers untouched
      else if (sck_rise)
      begin
        sh_in_r   <= {sh_in_r[30:0], mosi_s};
        bit_cnt_r <= bit_cnt_r + 6'd1;
        if (bit_cnt_r == `AFC_CMD_LAST)
        begin
          cmd_r       <= {sh_in_r[6:0], mosi_s};
          load_pend_r <= 1'b1;
        end
        if (bit_cnt_r == `AFC_FRAME_LAST)
          frame_done_r <= 1'b1;
      end
      // two cycles: memory read port must see the new address first
      if (load_go_r)
        sh_out_r <= rd_mux;
      else if (sck_fall && bit_cnt_r > `AFC_CMD_BITS)
        sh_out_r <= {sh_out_r[22:0], 1'b0};
    end
  end

  // out pin released unless this device owns the data phase
  assign miso_o    = sh_out_r[23];
  assign miso_oe_n = ~(~cs_n_s & sel & is_rd & (bit_cnt_r >= `AFC_CMD_BITS));

  // ****************************************
  // configuration registers
  // ****************************************
  reg  [`AFC_CH_W-1:0]   chcfg_r;
  reg  [`AFC_AFE_W-1:0]  afe_r;
  reg  [`AFC_FILT_W-1:0] filt_r [0:3];
  reg  [23:0]            gain_r [0:3];
  reg  [23:0]            offs_r [0:3];
  reg  [`AFC_ST_W-1:0]   stat_r;
  reg  [23:0]            data_r;
  integer                i;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      chcfg_r <= `AFC_CH_RST;
      afe_r   <= `AFC_AFE_RST;
      for (i = 0; i < `AFC_NCH; i = i + 1)
      begin
        filt_r[i] <= `AFC_FILT_RST;
        gain_r[i] <= `AFC_GAIN_RST;
        offs_r[i] <= `AFC_OFFS_RST;
      end
    end
    else if (wr_stb)
    begin
      if (addr == `AFC_A_CHCFG)
        chcfg_r <= wdat[`AFC_CH_W-1:0];
      if (addr == `AFC_A_AFE)
        afe_r <= wdat[`AFC_AFE_W-1:0];
      if (addr == `AFC_A_FILT)
        for (i = 0; i < `AFC_NCH; i = i + 1)
          if (chcfg_r[i])
            filt_r[i] <= wdat[`AFC_FILT_W-1:0];
      if (in_bank(addr, `AFC_A_GAIN0))
        gain_r[bidx] <= wdat;
      if (in_bank(addr, `AFC_A_OFFS0))
        offs_r[oidx] <= wdat;
    end
  end

  // ****************************************
  // protection and result capture
  // ****************************************
  // fresh detection beats a simultaneous clear
  always @(posedge mclk)
  begin
    if (srst)
    begin
      stat_r      <= 3'h0;
      hv_shutdown <= 1'b0;
      data_r      <= 24'h000000;
    end
    else
    begin
      if (wr_stb && addr == `AFC_A_STAT)
        stat_r <= (stat_r & ~wdat[`AFC_ST_W-1:0]) | prot_s;
      else
        stat_r <= stat_r | prot_s;
      hv_shutdown <= |(stat_r | prot_s);
      if (conv_valid)
        data_r <= conv_data;
    end
  end

  // ****************************************
  // clock source control
  // ****************************************
  always @(posedge mclk)
  begin
    if (srst)
    begin
      adc_osc_en           <= 1'b1;
      afe_osc_en           <= 1'b1;
      clock_inout_pin_oe_n <= 1'b1;
    end
    else
    begin
      adc_osc_en           <= (adc_clk_sel != `AFC_CLK_PIN);
      afe_osc_en           <= (afe_clk_sel != `AFC_CLK_PIN);
      clock_inout_pin_oe_n <= (adc_clk_sel != `AFC_CLK_DRV);
    end
  end

  // ****************************************
  // calibration store
  // ****************************************
  wire [4:0]  cal_idx = imode ? `AFC_A_CAL_CUR : {1'b0, pga_gain};
  wire [23:0] cal_rd;
  wire        cal_we  = wr_stb & (addr <= `AFC_A_CAL_CUR);

  afc_cal_mem u_cal
  (
    .mclk    (mclk),
    .we      (cal_we),
    .waddr   (addr),
    .wdata   (wdat),
    .raddr_a (addr),
    .rdata_a (cal_rd),
    .raddr_b (cal_idx),
    .rdata_b (gain_coef)
  );

  // ****************************************
  // read-back mux
  // ****************************************
  always @*
  begin
    rd_mux = 24'h000000;
    if (addr <= `AFC_A_CAL_CUR)
      rd_mux = cal_rd;
    else if (addr == `AFC_A_FILT)
      rd_mux = {13'h0000, filt_r[low_chan(chcfg_r[`AFC_CH_EN_HI:0])]};
    else if (addr == `AFC_A_CHCFG)
      rd_mux = {10'h000, chcfg_r};
    else if (in_bank(addr, `AFC_A_GAIN0))
      rd_mux = gain_r[bidx];
    else if (in_bank(addr, `AFC_A_OFFS0))
      rd_mux = offs_r[oidx];
    else if (addr == `AFC_A_AFE)
      rd_mux = {10'h000, afe_r};
    else if (addr == `AFC_A_STAT)
      rd_mux = {20'h00000, hv_shutdown, stat_r};
    else if (addr == `AFC_A_DATA)
      rd_mux = data_r;
  end

  // ****************************************
  // output fan-out
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `AFC_NCH; g = g + 1)
    begin : g_flat
      assign filt_flat[g*`AFC_FILT_W +: `AFC_FILT_W] = filt_r[g];
      assign gain_flat[g*24 +: 24] = gain_r[g];
      assign offs_flat[g*24 +: 24] = offs_r[g];
    end
  endgenerate

  assign chan_en     = chcfg_r[`AFC_CH_EN_HI:0];
  assign imode       = chcfg_r[`AFC_CH_IMODE];
  assign pga_gain    = chcfg_r[`AFC_CH_PGA_HI:`AFC_CH_PGA_LO];
  assign adc_clk_sel = chcfg_r[`AFC_CH_ACLK_HI:`AFC_CH_ACLK_LO];
  assign afe_clk_sel = chcfg_r[`AFC_CH_FCLK_HI:`AFC_CH_FCLK_LO];
  assign bias_voltage_generator_en = chcfg_r[`AFC_CH_BIAS_VOLTAGE_GENERATOR];
  assign pull_ctrl   = afe_r[`AFC_AFE_PULL_HI:0];
  assign excite_ctrl = afe_r[`AFC_AFE_EXC_HI:`AFC_AFE_EXC_LO];
  assign prot_flags  = stat_r;

endmodule // afc_cfg_top

`default_nettype wire

// ### afc_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module afc_spi_host
(
  output var logic sclk,      // serial clock, idle low
  output var logic cs_n,      // frame select
  output var logic mosi,      // serial data
  input wire logic miso_o,    // device data
  input wire logic miso_oe_n  // device drive
);
  // released line floats to its pull-up
  wire miso_line = miso_oe_n ? 1'b1 : miso_o;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // 400 ns serial period, bits sampled just before each rise
  task automatic frame(input logic [1:0] dev, input logic rd, input logic [4:0] a,
    input logic [23:0] d, output logic [23:0] q, output logic seen);
    logic [31:0] w;
    w = {dev, rd, a, d};
    q = 24'h0;
    seen = 1'b0;
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      mosi = w[i];
      #200;
      if (i < 24)
      begin
        q[i] = miso_line;
        seen = seen | !miso_oe_n;
      end
      sclk = 1'b1;
      #200;
      sclk = 1'b0;
    end
    // stale data line would hide a late sample
    mosi = !mosi;
    #200;
    cs_n = 1'b1;
    #400;
  endtask
endmodule // afc_spi_host
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "afc_cfg_regs.vh"
module tb;
  logic        mclk, srst, device_select_pin_low, device_select_pin_high;
  logic        oc_det, ov_det, ot_det, conv_valid;
  logic [23:0] conv_data, q, ev, gv [4], ov [4], cal [17];
  logic [10:0] fw;
  logic [1:0]  dev;
  logic        s;
  wire         sclk, cs_n, mosi, miso_o, miso_oe_n, imode, adc_osc_en, afe_osc_en;
  wire         clock_inout_pin_oe_n, bias_voltage_generator_en, hv_shutdown;
  wire  [43:0] filt_flat;
  wire  [95:0] gain_flat, offs_flat;
  wire  [3:0]  chan_en, pga_gain;
  wire  [1:0]  adc_clk_sel, afe_clk_sel;
  wire  [7:0]  pull_ctrl;
  wire  [5:0]  excite_ctrl;
  wire  [2:0]  prot_flags;
  wire  [23:0] gain_coef;
  int          bad_count, comparisons, seed;

  afc_cfg_top dut (.mclk, .srst, .sclk, .cs_n, .mosi, .miso_o, .miso_oe_n,
    .device_select_pin_low, .device_select_pin_high, .oc_det, .ov_det, .ot_det,
    .conv_data, .conv_valid, .filt_flat, .gain_flat, .offs_flat, .chan_en, .imode,
    .pga_gain, .adc_clk_sel, .afe_clk_sel, .adc_osc_en, .afe_osc_en,
    .clock_inout_pin_oe_n, .bias_voltage_generator_en, .pull_ctrl, .excite_ctrl,
    .prot_flags, .hv_shutdown, .gain_coef);
  afc_spi_host host (.sclk, .cs_n, .mosi, .miso_o, .miso_oe_n);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = !mclk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input logic [1:0] dv, input logic rd, input logic [4:0] a,
    input logic [23:0] d);
    host.frame(dv, rd, a, d, q, s);
    step(2);
  endtask
  function automatic logic [23:0] cc(input logic [3:0] en, input logic im,
    input logic [3:0] pga, input logic [1:0] ac, input logic [1:0] fc, input logic b);
    return {10'h000, b, fc, ac, pga, im, en};
  endfunction

  initial
  begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    print_verdict;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 29;
    srst = 1'b1;
    {oc_det, ov_det, ot_det, conv_valid} = 4'h0;
    conv_data = 24'h000000;
    dev = 2'($random(seed));
    {device_select_pin_high, device_select_pin_low} = dev;
    step(5);
    srst = 1'b0;
    step(4);
    check("gain rst", gain_flat, {4{`AFC_GAIN_RST}});
    check("offs rst", offs_flat, {4{`AFC_OFFS_RST}});
    check("filt rst", filt_flat, 44'h0);
    check("cfg rst", {bias_voltage_generator_en, afe_clk_sel, adc_clk_sel, pga_gain, imode,
      chan_en, adc_osc_en, afe_osc_en, clock_inout_pin_oe_n}, {`AFC_CH_RST, 3'h7});
    check("prot rst", {prot_flags, hv_shutdown, miso_oe_n}, 5'h01);
    for (int n = 0; n < 4; n++)
    begin
      gv[n] = $random(seed);
      ov[n] = $random(seed);
      xfer(dev, 1'b0, 5'(`AFC_A_GAIN0 + n), gv[n]);
      xfer(dev, 1'b0, 5'(`AFC_A_OFFS0 + n), ov[n]);
    end
    check("gain", gain_flat, {gv[3], gv[2], gv[1], gv[0]});
    check("offs", offs_flat, {ov[3], ov[2], ov[1], ov[0]});
    xfer(dev, 1'b1, 5'(`AFC_A_OFFS0 + 2), 24'h0);
    check("read offs2", q, ov[2]);
    xfer(dev ^ 2'h1, 1'b0, `AFC_A_GAIN0, ~gv[0]);
    check("foreign write", gain_flat[23:0], gv[0]);
    xfer(dev ^ 2'h2, 1'b1, `AFC_A_GAIN0, 24'h0);
    check("foreign drive", s, 1'b0);
    // shared filter address, channels 0 and 2 enabled
    xfer(dev, 1'b0, `AFC_A_CHCFG, cc(4'h5, 1'b0, 4'h0, 2'h0, 2'h0, 1'b0));
    for (int t = 0; t < 3; t++)
    begin
      fw = {9'($random(seed)), 2'(t)};
      xfer(dev, 1'b0, `AFC_A_FILT, 24'(fw));
      check("filt", filt_flat, {11'h0, fw, 11'h0, fw});
    end
    xfer(dev, 1'b0, `AFC_A_CHCFG, cc(4'h0, 1'b0, 4'h0, 2'h0, 2'h0, 1'b0));
    xfer(dev, 1'b0, `AFC_A_FILT, 24'h0007ff);
    check("filt none", filt_flat, {11'h0, fw, 11'h0, fw});
    for (int g = 0; g < 17; g++)
    begin
      cal[g] = $random(seed);
      xfer(dev, 1'b0, 5'(g), cal[g]);
    end
    xfer(dev, 1'b1, `AFC_A_CAL_CUR, 24'h0);
    check("read cal", q, cal[16]);
    for (int g = 0; g < 16; g++)
    begin
      xfer(dev, 1'b0, `AFC_A_CHCFG, cc(4'h1, 1'b0, 4'(g), 2'h0, 2'h0, 1'b0));
      check("coef v", gain_coef, cal[g]);
    end
    xfer(dev, 1'b0, `AFC_A_CHCFG, cc(4'h1, 1'b1, 4'h9, 2'h0, 2'h0, 1'b0));
    check("coef i", gain_coef, cal[16]);
    xfer(dev, 1'b0, `AFC_A_CHCFG, cc(4'h1, 1'b0, 4'h0, 2'h1, 2'h2, 1'b1));
    check("clk drive", {adc_osc_en, afe_osc_en, clock_inout_pin_oe_n,
      bias_voltage_generator_en}, 4'b1001);
    xfer(dev, 1'b0, `AFC_A_CHCFG, cc(4'h1, 1'b0, 4'h0, 2'h2, 2'h0, 1'b0));
    check("clk pin", {adc_osc_en, afe_osc_en, clock_inout_pin_oe_n,
      bias_voltage_generator_en}, 4'b0110);
    ev = $random(seed);
    xfer(dev, 1'b0, `AFC_A_AFE, ev);
    check("afe", {excite_ctrl, pull_ctrl}, ev[13:0]);
    for (int p = 0; p < 3; p++)
    begin
      {ot_det, ov_det, oc_det} = 3'(1 << p);
      step(2);
      {ot_det, ov_det, oc_det} = 3'h0;
      step(6);
      check("flag", {prot_flags, hv_shutdown}, {3'(1 << p), 1'b1});
      xfer(dev, 1'b0, `AFC_A_STAT, 24'h000007);
      check("clear", {prot_flags, hv_shutdown}, 4'h0);
    end
    conv_data = $random(seed);
    conv_valid = 1'b1;
    step(1);
    conv_valid = 1'b0;
    xfer(dev, 1'b1, `AFC_A_DATA, 24'h0);
    check("result", q, conv_data);
    print_verdict;
  end
endmodule // tb
`default_nettype wire
